// ### hw/atc_adc_ctrl.sv
// Purpose: converter end: mode steering, selective truncation, lanes, calibration
// Assumes: coreSample holds each sub-converter's two's complement result
// Notes: power-on reset stands in for power-up
`timescale 1ns/1ps
module atc_adc_ctrl import atc_pkg::*; #(
  parameter int CAL_CYCLES = CAL_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic resetn,
  atc_link_if.dev link,
  input wire logic [SAMPLE_W-1:0] coreSample [NUM_SUB],
  input wire logic [NUM_SUB*SEED_W-1:0] noiseSeed,
  output logic [1:0] convInputSel [NUM_CONV],
  output logic [1:0] convPhase [NUM_CONV],
  output logic sampleBothEdges,
  output logic dcCoupledMode,
  output logic calRunning,
  output logic powerDownActive
);
  typedef enum logic [3:0] {
    CS_WAIT = 4'h1,
    CS_IDLE = 4'h2,
    CS_RUN = 4'h4,
    CS_PDN = 4'h8
  } atc_cal_state_t;

  atc_cal_state_t calState;
  logic [2:0] calSh;
  logic [2:0] pdSh;
  logic calLvl;
  logic pdLvl;
  logic [2:0] settleCnt;
  logic seedLoad;
  logic pdnNext;
  logic puPending;
  logic [DET_CNT_W-1:0] lowCnt;
  logic [DET_CNT_W-1:0] highCnt;
  logic cmdValid;
  logic regPrev;
  logic regRise;
  logic [CAL_CNT_W-1:0] calCnt;
  logic [1:0] phase;
  logic [SAMPLE_W-1:0] subOut [NUM_SUB];
  logic [SAMPLE_W-1:0] dlData [DL_DEPTH][2];
  logic [DL_DEPTH-1:0] dlValid;
  logic [3:0] lanePtr;
  logic [3:0] lanePtrOdd;
  logic [NUM_LANES-1:0] laneRd;
  logic [10:0] enc0;
  logic [10:0] enc1;

  // fold a raw noise value into the counter range
  function automatic logic [4:0] seedFold(input logic [SEED_W-1:0] v);
    return (v >= 5'(TRUNC_MOD)) ? 5'(v - 5'(TRUNC_MOD)) : v;
  endfunction

  // pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      calSh <= 3'h0;
      pdSh <= 3'h0;
      calLvl <= 1'b0;
      pdLvl <= 1'b0;
    end else begin
      calSh <= {calSh[1:0], link.calPin};
      pdSh <= {pdSh[1:0], link.powerDown};
      if (calSh[1] == calSh[2]) calLvl <= calSh[2];
      if (pdSh[1] == pdSh[2]) pdLvl <= pdSh[2];
    end
  end

  assign seedLoad = (calState == CS_WAIT) && (settleCnt == SETTLE_CYC);
  assign regRise = link.calRegBit & ~regPrev;
  assign calRunning = (calState == CS_RUN);
  assign powerDownActive = (calState == CS_PDN);
  assign pdnNext = pdLvl && (calState == CS_IDLE || calState == CS_PDN ||
                             (calState == CS_RUN && calCnt == '0));

  // pin command detector: long low, then long high
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lowCnt <= '0;
      highCnt <= '0;
      cmdValid <= 1'b0;
      regPrev <= 1'b0;
    end else begin
      regPrev <= link.calRegBit;
      cmdValid <= 1'b0;
      if (pdLvl) begin
        lowCnt <= '0;
        highCnt <= '0;
      end else if (!calLvl) begin
        highCnt <= '0;
        if (lowCnt != DET_CNT_W'(CAL_LOW_MIN)) lowCnt <= lowCnt + 7'h01;
      end else if (lowCnt == DET_CNT_W'(CAL_LOW_MIN)) begin
        if (highCnt == DET_CNT_W'(CAL_HIGH_MIN - 1)) begin
          cmdValid <= 1'b1;
          lowCnt <= '0;
          highCnt <= '0;
        end else begin
          highCnt <= highCnt + 7'h01;
        end
      end else begin
        lowCnt <= '0; // high without a full low phase
      end
    end
  end

  // calibration sequencer with power-down hand-off
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      calState <= CS_WAIT;
      settleCnt <= 3'h0;
      puPending <= 1'b1;
      calCnt <= '0;
    end else begin
      unique case (calState)
        CS_WAIT: begin
          settleCnt <= settleCnt + 3'h1;
          if (seedLoad) begin
            calState <= CS_IDLE;
            puPending <= ~calLvl;
          end
        end
        CS_IDLE: begin
          if (pdLvl) begin
            calState <= CS_PDN;
          end else if (puPending || cmdValid || regRise) begin
            calState <= CS_RUN;
            puPending <= 1'b0;
            calCnt <= CAL_CNT_W'(CAL_CYCLES - 1);
          end
        end
        CS_RUN: begin
          calCnt <= calCnt - 22'h000001;
          if (calCnt == '0) calState <= pdLvl ? CS_PDN : CS_IDLE;
        end
        CS_PDN: begin
          if (!pdLvl) calState <= CS_IDLE;
        end
      endcase
    end
  end

  // converter steering and sampling phase per mode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < NUM_CONV; c++) begin
        convInputSel[c] <= 2'h0;
        convPhase[c] <= 2'h0;
      end
      sampleBothEdges <= 1'b0;
      dcCoupledMode <= 1'b0;
    end else begin
      dcCoupledMode <= link.dcCoupledSel;
      unique case (link.mode)
        ATC_SINGLE: begin
          for (int c = 0; c < NUM_CONV; c++) begin
            convInputSel[c] <= 2'h0;
            convPhase[c] <= 2'(c);
          end
          sampleBothEdges <= 1'b1;
        end
        ATC_DUAL: begin
          convInputSel[0] <= {1'b0, link.inSelAC};
          convInputSel[2] <= {1'b0, link.inSelAC};
          convInputSel[1] <= {1'b1, link.inSelBD};
          convInputSel[3] <= {1'b1, link.inSelBD};
          convPhase[0] <= 2'h0;
          convPhase[1] <= 2'h0;
          convPhase[2] <= 2'h2;
          convPhase[3] <= 2'h2;
          sampleBothEdges <= 1'b1;
        end
        default: begin
          convInputSel[0] <= 2'h0;
          convInputSel[2] <= 2'h1;
          convInputSel[1] <= 2'h2;
          convInputSel[3] <= 2'h3;
          for (int c = 0; c < NUM_CONV; c++) convPhase[c] <= 2'h0;
          sampleBothEdges <= 1'b0;
        end
      endcase
    end
  end

  // sub-converter sampling phase
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) phase <= 2'h0;
    else phase <= phase + 2'h1;
  end

  // per-sub truncation counter, delay latch and pattern position
  for (genvar k = 0; k < NUM_SUB; k++) begin : g_sub
    localparam logic [1:0] PH = 2'(k % 4);
    logic [4:0] cnt;
    logic hitLatch;
    logic [2:0] pos;
    logic takes;
    logic hit;
    assign takes = (phase == PH);
    assign hit = hitLatch | (cnt == TRIG_VAL[k]);
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        cnt <= 5'h00;
        hitLatch <= 1'b0;
        pos <= 3'h0;
      end else begin
        if (seedLoad) cnt <= seedFold(noiseSeed[k*SEED_W +: SEED_W]);
        else cnt <= (cnt == 5'(TRUNC_MOD - 1)) ? 5'h00 : cnt + 5'h01;
        if (takes) hitLatch <= 1'b0;
        else if (cnt == TRIG_VAL[k]) hitLatch <= 1'b1;
        if (takes && !hit) pos <= pos + 3'h1;
      end
    end
    // offset binary, LSB dropped where the pattern says and no delay
    assign subOut[k] = {~coreSample[k][7], coreSample[k][6:1],
                        coreSample[k][0] & (hit | ~TRUNC_MASK[pos])};
  end

  // latency line: earlier (delayed) sub first, then current
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dlValid <= '0;
      for (int i = 0; i < DL_DEPTH; i++) begin
        dlData[i][0] <= '0;
        dlData[i][1] <= '0;
      end
    end else begin
      dlValid <= pdnNext ? '0 : {dlValid[DL_DEPTH-2:0], calState != CS_WAIT};
      dlData[0][0] <= subOut[{1'b1, phase}];
      dlData[0][1] <= subOut[{1'b0, phase}];
      for (int i = 1; i < DL_DEPTH; i++) dlData[i] <= dlData[i-1];
    end
  end

  assign lanePtrOdd = lanePtr + 4'h1;
  assign enc0 = atc_enc(dlData[DL_DEPTH-1][0], laneRd[lanePtr]);
  assign enc1 = atc_enc(dlData[DL_DEPTH-1][1], laneRd[lanePtrOdd]);

  // lane distribution with per-lane running disparity
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int l = 0; l < NUM_LANES; l++) link.laneWord[l] <= '0;
      link.laneValid <= '0;
      laneRd <= '0;
      lanePtr <= 4'h0;
    end else begin
      link.laneValid <= '0;
      if (dlValid[DL_DEPTH-1] && !pdnNext) begin
        link.laneWord[lanePtr] <= enc0[9:0];
        link.laneWord[lanePtrOdd] <= enc1[9:0];
        laneRd[lanePtr] <= enc0[10];
        laneRd[lanePtrOdd] <= enc1[10];
        link.laneValid[lanePtr] <= 1'b1;
        link.laneValid[lanePtrOdd] <= 1'b1;
        lanePtr <= (lanePtr == 4'(NUM_LANES - 2)) ? 4'h0 : lanePtr + 4'h2;
      end
    end
  end
endmodule // atc_adc_ctrl

// ### hw/atc_pkg.sv
// Purpose: shared constants, types and 8b/10b code tables for both ends
// Assumes: one clock, mclk at 50 MHz, on both ends
// Notes: code tables are the running-disparity-negative forms
package atc_pkg;
  localparam int NUM_CONV = 4;
  localparam int NUM_SUB = 8;
  localparam int NUM_LANES = 10;
  localparam int SAMPLE_W = 8;
  localparam int CODE_W = 10;
  localparam int SEED_W = 5;
  localparam int MCLK_MHZ = 50;
  // truncation: modulo counter and the 8-sample pattern (offsets 2, 4, 7)
  localparam int TRUNC_MOD = 26;
  localparam logic [7:0] TRUNC_MASK = 8'h94;
  // per-sub trigger values, all distinct and below TRUNC_MOD
  localparam logic [4:0] TRIG_VAL [NUM_SUB] = '{5'h02, 5'h05, 5'h08, 5'h0b,
                                                5'h0e, 5'h11, 5'h14, 5'h17};
  // calibration command and run time, in input clock cycles
  localparam int CAL_LOW_MIN = 80;
  localparam int CAL_HIGH_MIN = 80;
  localparam int CAL_MARGIN = 4;
  localparam int CAL_CYCLES_DEF = 2895000;
  localparam int CAL_CNT_W = 22;
  localparam int DET_CNT_W = 7;
  localparam int GEN_CNT_W = 8;
  // cycles after reset before pin levels are trusted
  localparam logic [2:0] SETTLE_CYC = 3'h5;
  // sample capture to lane word, 38..42 allowed
  localparam int LATENCY_CYC = 40;
  localparam int DL_DEPTH = LATENCY_CYC;
  typedef enum logic [1:0] {
    ATC_SINGLE = 2'h0,
    ATC_DUAL = 2'h1,
    ATC_QUAD = 2'h2
  } atc_mode_t;
  localparam atc_mode_t MODE_RST = ATC_QUAD;
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [3:0] T4_ALT7 = 4'h7;

  // 8b/10b encode; returns {new disparity, abcdei fghj}
  function automatic logic [10:0] atc_enc(input logic [7:0] d, input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic rd1;
    logic rd2;
    c6 = T6[d[4:0]];
    c4 = T4[d[7:5]];
    rd1 = ~rd;
    if ($countones(c6) == 3) begin
      rd1 = rd;
      if (rd && d[4:0] == 5'h07) c6 = ~c6;
    end else if (rd) begin
      c6 = ~c6;
    end
    if (d[7:5] == 3'h7 && (rd1 ? (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e)
                               : (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)))
      c4 = T4_ALT7;
    rd2 = ~rd1;
    if ($countones(c4) == 2) begin
      rd2 = rd1;
      if (rd1 && d[7:5] == 3'h3) c4 = ~c4;
    end else if (rd1) begin
      c4 = ~c4;
    end
    return {rd2, c6, c4};
  endfunction

  // 8b/10b decode; returns {code error, byte}
  function automatic logic [8:0] atc_dec(input logic [9:0] c);
    logic [4:0] x;
    logic [2:0] y;
    logic hit6;
    logic hit4;
    x = '0;
    y = '0;
    hit6 = 1'b0;
    hit4 = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (c[9:4] == T6[i] || (c[9:4] == ~T6[i] && ($countones(T6[i]) != 3 || i == 7))) begin
        x = 5'(i);
        hit6 = 1'b1;
      end
    end
    for (int j = 0; j < 8; j++) begin
      if (c[3:0] == T4[j] || (c[3:0] == ~T4[j] && ($countones(T4[j]) != 2 || j == 3))) begin
        y = 3'(j);
        hit4 = 1'b1;
      end
    end
    if (c[3:0] == T4_ALT7 || c[3:0] == ~T4_ALT7) begin
      y = 3'h7;
      hit4 = 1'b1;
    end
    return {~(hit6 & hit4), y, x};
  endfunction
endpackage

// ### hw/atc_link_if.sv
// Purpose: joins the converter control end and the receiver end
// Assumes: both ends on mclk; calPin and powerDown are pins to the device
// Notes: lane words are parallel 10-bit codes with a one-cycle strobe per lane
`timescale 1ns/1ps
interface atc_link_if;
  import atc_pkg::*;
  logic [CODE_W-1:0] laneWord [NUM_LANES];
  logic [NUM_LANES-1:0] laneValid;
  logic calPin;
  logic calRegBit;
  logic powerDown;
  atc_mode_t mode;
  logic inSelAC;
  logic inSelBD;
  logic dcCoupledSel;
  modport dev(output laneWord, laneValid,
              input calPin, calRegBit, powerDown, mode, inSelAC, inSelBD, dcCoupledSel);
  modport rcv(input laneWord, laneValid,
              output calPin, calRegBit, powerDown, mode, inSelAC, inSelBD, dcCoupledSel);
endinterface

// ### hw/atc_rcv.sv
// Purpose: receiver end: configuration, calibration requests, lane decode
// Assumes: lanes arrive in pairs, earlier sample on the even lane
// Notes: calibration pin idles low so power-up calibration is not skipped
`timescale 1ns/1ps
module atc_rcv import atc_pkg::*; (
  input wire logic mclk,
  input wire logic resetn,
  atc_link_if.rcv link,
  input wire logic calCmd,
  input wire logic calByReg,
  input wire logic fsrChanged,
  input wire logic tempEvent,
  input wire logic powerDownReq,
  input wire atc_mode_t modeSel,
  input wire logic inSelAC,
  input wire logic inSelBD,
  input wire logic dcCoupledSel,
  output logic [SAMPLE_W-1:0] sampleOut [2],
  output logic sampleValid,
  output logic codeErr,
  output logic calPinBusy
);
  typedef enum logic [2:0] {
    GS_IDLE = 3'h1,
    GS_LOW = 3'h2,
    GS_HIGH = 3'h4
  } atc_gen_state_t;

  atc_gen_state_t genState;
  logic [GEN_CNT_W-1:0] genCnt;
  logic regPend;
  logic [3:0] ptr;
  logic [3:0] ptrOdd;
  logic [8:0] dec0;
  logic [8:0] dec1;
  logic [3:0] firstPair;

  assign calPinBusy = (genState != GS_IDLE);

  // configuration to the device
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link.mode <= MODE_RST;
      link.inSelAC <= 1'b0;
      link.inSelBD <= 1'b0;
      link.dcCoupledSel <= 1'b0;
      link.powerDown <= 1'b0;
    end else begin
      link.mode <= modeSel;
      link.inSelAC <= inSelAC;
      link.inSelBD <= inSelBD;
      link.dcCoupledSel <= dcCoupledSel;
      link.powerDown <= powerDownReq;
    end
  end

  // calibration pin sequence: low phase then high phase, with margin
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      genState <= GS_IDLE;
      genCnt <= '0;
      link.calPin <= 1'b0;
    end else begin
      genCnt <= genCnt + 8'h01;
      unique case (genState)
        GS_IDLE: begin
          if (calCmd || fsrChanged || tempEvent) begin
            genState <= GS_LOW;
            genCnt <= '0;
          end
        end
        GS_LOW: begin
          if (genCnt == GEN_CNT_W'(CAL_LOW_MIN + CAL_MARGIN - 1)) begin
            genState <= GS_HIGH;
            genCnt <= '0;
            link.calPin <= 1'b1;
          end
        end
        GS_HIGH: begin
          if (genCnt == GEN_CNT_W'(CAL_HIGH_MIN + CAL_MARGIN - 1)) begin
            genState <= GS_IDLE;
            link.calPin <= 1'b0;
          end
        end
      endcase
    end
  end

  // register bit: cleared first when already set, then set again
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link.calRegBit <= 1'b0;
      regPend <= 1'b0;
    end else if (regPend) begin
      link.calRegBit <= 1'b1;
      regPend <= 1'b0;
    end else if (calByReg) begin
      if (link.calRegBit) begin
        link.calRegBit <= 1'b0;
        regPend <= 1'b1;
      end else begin
        link.calRegBit <= 1'b1;
      end
    end
  end

  // lowest even lane carrying a word, used to regain pair alignment
  always_comb begin
    firstPair = 4'h0;
    for (int l = NUM_LANES - 2; l >= 0; l -= 2) begin
      if (link.laneValid[l]) firstPair = 4'(l);
    end
  end

  assign ptrOdd = ptr + 4'h1;
  assign dec0 = atc_dec(link.laneWord[ptr]);
  assign dec1 = atc_dec(link.laneWord[ptrOdd]);

  // decode lanes in turn and rebuild the sample order
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ptr <= 4'h0;
      sampleOut[0] <= '0;
      sampleOut[1] <= '0;
      sampleValid <= 1'b0;
      codeErr <= 1'b0;
    end else begin
      sampleValid <= 1'b0;
      codeErr <= 1'b0;
      if (link.laneValid[ptr] && link.laneValid[ptrOdd]) begin
        sampleOut[0] <= dec0[7:0];
        sampleOut[1] <= dec1[7:0];
        sampleValid <= 1'b1;
        codeErr <= dec0[8] | dec1[8];
        ptr <= (ptr == 4'(NUM_LANES - 2)) ? 4'h0 : ptr + 4'h2;
      end else if (|link.laneValid) begin
        ptr <= firstPair;
      end
    end
  end
endmodule // atc_rcv

// ### testbench/atc_link_props.sv
// Purpose: link checks between the converter end and the receiver end
// Assumes: one clock, resetn active low, CAL_CYCLES shortened in simulation
// Notes: pin run counters saturate at 255
`timescale 1ns/1ps
module atc_link_props import atc_pkg::*; #(
  parameter int CAL_CYCLES = CAL_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [NUM_LANES-1:0] laneValid,
  input wire logic calPin,
  input wire logic calRegBit,
  input wire logic powerDown,
  input wire logic calRunning,
  input wire logic powerDownActive
);
  logic [7:0] loCnt;
  logic [7:0] hiCnt;
  logic [7:0] okAge;
  logic [7:0] upCnt;
  logic [CAL_CNT_W-1:0] runCnt;
  logic [NUM_LANES-1:0] lvPrev;
  logic bitPrev;
  logic [1:0] regRise;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // pin low run, armed high run, age of the last full command
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      loCnt <= 8'h00;
      hiCnt <= 8'h00;
      okAge <= 8'hff;
    end else begin
      loCnt <= calPin ? 8'h00 : loCnt + 8'(loCnt != 8'hff);
      hiCnt <= (!calPin || (hiCnt == 8'h00 && loCnt < 8'h50)) ? 8'h00
               : hiCnt + 8'(hiCnt != 8'hff);
      okAge <= (hiCnt >= 8'h50) ? 8'h00 : okAge + 8'(okAge != 8'hff);
    end
  end

  // time since reset, run length, previous strobes, register bit rises
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      upCnt <= 8'h00;
      runCnt <= '0;
      lvPrev <= '0;
      bitPrev <= 1'b0;
      regRise <= 2'h0;
    end else begin
      upCnt <= upCnt + 8'(upCnt != 8'hff);
      runCnt <= calRunning ? runCnt + 1'b1 : '0;
      lvPrev <= laneValid;
      bitPrev <= calRegBit;
      regRise <= {regRise[0], calRegBit & ~bitPrev};
    end
  end

  // a full low phase, then the pin rising and held high nine cycles, on an idle device
  sequence pinCmd;
    $rose(calPin) && loCnt >= 8'h50 && !calRunning && !powerDown && !powerDownActive
      ##1 calPin [*8];
  endsequence
  sequence calStart;
    $rose(calRunning);
  endsequence

  AST_LANE_PAIR: assert property (
    laneValid inside {10'h000, 10'h003, 10'h00c, 10'h030, 10'h0c0, 10'h300})
    else $error("lane strobes are not one pair");
  AST_LANE_TURN: assert property (
    lvPrev != 10'h000 && laneValid != 10'h000 |-> laneValid == {lvPrev[7:0], lvPrev[9:8]})
    else $error("lane pairs out of turn");
  AST_LANE_PD: assert property (
    powerDownActive |-> laneValid == 10'h000)
    else $error("lanes strobed in power down");
  AST_CAL_LEN: assert property (
    $fell(calRunning) |-> runCnt == CAL_CYCLES)
    else $error("calibration length wrong");
  AST_REG_START: assert property (
    $rose(calRegBit) && !calRunning && !powerDown && !powerDownActive && upCnt > 8'h14
      |-> ##[1:2] calStart)
    else $error("register request did not start calibration");
  AST_REG_HOLD: assert property (
    $fell(calRunning) && calRegBit |=> !calRunning [*8])
    else $error("steady register bit restarted calibration");
  AST_CAL_CAUSE: assert property (
    calStart |-> okAge < 8'h10 || regRise != 2'h0 || upCnt < 8'h10 || $past(powerDownActive))
    else $error("calibration started without a valid request");
  AST_PIN_ANSWER: assert property (
    pinCmd |-> ##[70:90] calStart)
    else $error("pin command not answered in time");
  AST_PD_HOLD: assert property (
    calRunning |-> !powerDownActive)
    else $error("power down during calibration");
endmodule // atc_link_props

// ### testbench/adc_truncation_and_calibration_control_tb.sv
// Purpose: drives both ends through modes, data, calibration and power down
// Assumes: calibration shortened to 20 cycles, inputs change at falling edges
// Notes: samples with LSB clear pass truncation unchanged
`timescale 1ns/1ps
module adc_truncation_and_calibration_control_tb import atc_pkg::*;;
  localparam int CALC = 20;
  logic mclk;
  logic resetn;
  logic [SAMPLE_W-1:0] coreSample [NUM_SUB];
  logic calCmd;
  logic calByReg;
  logic fsrChanged;
  logic tempEvent;
  logic powerDownReq;
  atc_mode_t modeSel;
  logic inSelAC;
  logic inSelBD;
  logic dcCoupledSel;
  logic [1:0] convInputSel [NUM_CONV];
  logic [1:0] convPhase [NUM_CONV];
  logic sampleBothEdges;
  logic dcCoupledMode;
  logic calRunning;
  logic powerDownActive;
  logic [SAMPLE_W-1:0] sampleOut [2];
  logic sampleValid;
  logic codeErr;
  logic calPinBusy;
  logic sawRun;
  int miscompares;
  int nTests;

  atc_link_if link ();
  atc_adc_ctrl #(.CAL_CYCLES(CALC)) atc_adc_ctrl_i (
    .mclk(mclk), .resetn(resetn), .link(link), .coreSample(coreSample),
    .noiseSeed(40'h9c4e271a3b), .convInputSel(convInputSel), .convPhase(convPhase),
    .sampleBothEdges(sampleBothEdges), .dcCoupledMode(dcCoupledMode),
    .calRunning(calRunning), .powerDownActive(powerDownActive));
  atc_rcv atc_rcv_i (
    .mclk(mclk), .resetn(resetn), .link(link), .calCmd(calCmd), .calByReg(calByReg),
    .fsrChanged(fsrChanged), .tempEvent(tempEvent), .powerDownReq(powerDownReq),
    .modeSel(modeSel), .inSelAC(inSelAC), .inSelBD(inSelBD), .dcCoupledSel(dcCoupledSel),
    .sampleOut(sampleOut), .sampleValid(sampleValid), .codeErr(codeErr),
    .calPinBusy(calPinBusy));
  atc_link_props #(.CAL_CYCLES(CALC)) atc_link_props_i (
    .mclk(mclk), .resetn(resetn), .laneValid(link.laneValid), .calPin(link.calPin),
    .calRegBit(link.calRegBit), .powerDown(link.powerDown), .calRunning(calRunning),
    .powerDownActive(powerDownActive));

  // free-running clock, 20 ns period
  always #10 mclk = ~mclk;
  // remembers any calibration seen since last cleared
  always @(posedge mclk) if (calRunning === 1'b1) sawRun <= 1'b1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one-cycle request: 0 pin command, 1 range change, 2 temperature, 3 register bit
  task automatic request(input int k);
    calCmd = (k == 0);
    fsrChanged = (k == 1);
    tempEvent = (k == 2);
    calByReg = (k == 3);
    tick(1);
    {calCmd, fsrChanged, tempEvent, calByReg} = 4'h0;
  endtask
  // waits for calRunning to reach a level, bounded
  task automatic waitCal(input logic lvl, input int lim, output int n);
    n = 0;
    while (calRunning !== lvl && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  // reads one decoded sample pair, bounded
  task automatic readPair(output logic [7:0] s0, output logic [7:0] s1);
    int n;
    n = 0;
    while (sampleValid !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    s0 = sampleOut[0];
    s1 = sampleOut[1];
    check(16'(codeErr), 16'h0);
    tick(1);
  endtask

  // watchdog well beyond the expected run
  initial begin
    #400000;
    miscompares++;
    results();
  end

  initial begin
    int n;
    int z;
    logic [7:0] s0;
    logic [7:0] s1;
    mclk = 1'b0;
    resetn = 1'b0;
    {calCmd, calByReg, fsrChanged, tempEvent, powerDownReq} = 5'h00;
    modeSel = ATC_QUAD;
    {inSelAC, inSelBD, dcCoupledSel, sawRun} = 4'h0;
    miscompares = 0;
    nTests = 0;
    foreach (coreSample[i]) coreSample[i] = 8'h36;
    tick(16);
    resetn = 1'b1;
    // power-up calibration starts alone and runs its length
    waitCal(1'b1, 40, n);
    check(16'(n < 40), 16'h1);
    waitCal(1'b0, 40, n);
    check(16'(n >= CALC - 1 && n <= CALC + 1), 16'h1);
    dcCoupledSel = 1'b1;
    tick(3);
    check(16'(dcCoupledMode), 16'h1);
    dcCoupledSel = 1'b0;
    tick(3);
    check(16'(dcCoupledMode), 16'h0);
    // phase slots in single, dual and quad, input steering in dual and quad
    for (int m = 0; m < 3; m++) begin
      modeSel = atc_mode_t'(m);
      inSelAC = 1'(m);
      inSelBD = ~1'(m);
      tick(4);
      for (int c = 0; c < NUM_CONV; c++) begin
        check(16'(convPhase[c]), 16'((m == 0) ? c : (m == 1) ? (c / 2) * 2 : 0));
        if (m == 1) check(16'(convInputSel[c]), 16'({c[0], c[0] ? inSelBD : inSelAC}));
        if (m == 2) check(16'(convInputSel[c]), 16'({c[0], c[1]}));
      end
      check(16'(sampleBothEdges), 16'(m != 2));
    end
    // offset binary output of an even-valued sample
    for (int i = 0; i < 8; i++) begin
      readPair(s0, s1);
      check({s0, s1}, 16'hb6b6);
    end
    // latency from a sample change to the decoded word
    foreach (coreSample[i]) coreSample[i] = 8'h5a;
    n = 0;
    while (sampleOut[1] !== 8'hda && n < 60) begin
      tick(1);
      n++;
    end
    check(16'(n >= 39 && n <= 43), 16'h1);
    // odd samples: LSB cleared three in eight, less where delayed
    foreach (coreSample[i]) coreSample[i] = 8'h37;
    tick(50);
    z = 0;
    for (int i = 0; i < 208; i++) begin
      readPair(s0, s1);
      z += int'(!s0[0]) + int'(!s1[0]);
      check({s0 | 8'h01, s1 | 8'h01}, 16'hb7b7);
    end
    check(16'(z > 104), 16'h1);
    check(16'(z < 150), 16'h1);
    // register bit starts one run; left set it starts no more
    request(3);
    waitCal(1'b1, 10, n);
    check(16'(n < 10), 16'h1);
    waitCal(1'b0, 40, n);
    sawRun = 1'b0;
    tick(60);
    check(16'(sawRun), 16'h0);
    // pin command from each request source
    for (int k = 0; k < 3; k++) begin
      request(k);
      check(16'(calPinBusy), 16'h1);
      waitCal(1'b1, 220, n);
      check(16'(n > 150 && n < 200), 16'h1);
      waitCal(1'b0, 40, n);
      tick(4);
    end
    // power down waits for calibration, then ignores commands
    request(3);
    waitCal(1'b1, 10, n);
    powerDownReq = 1'b1;
    tick(8);
    check(16'(powerDownActive), 16'h0);
    waitCal(1'b0, 40, n);
    tick(3);
    check(16'(powerDownActive), 16'h1);
    sawRun = 1'b0;
    request(0);
    tick(200);
    powerDownReq = 1'b0;
    tick(30);
    check({7'h00, sawRun, 7'h00, powerDownActive}, 16'h0000);
    results();
  end
endmodule // adc_truncation_and_calibration_control_tb
